/* core/scwcs_consts.svh */
// constants for the spi crc, window compare and statistics block
//------------------------------------------------------------
// Behaviour
//------------------------------------------------------------
// Behaviour
// - every link crc is 8 bits, polynomial x^8+x^2+x+1, same on both ends
// - with crc enabled, append crc to returned data and check all host input
// - device computes crc over received 24-bit payload, compares with host crc
// - with crc enabled, wrong clock count or crc mismatch is an input error
// - erroneous frame is dropped unexecuted and the input error flag is set
// - flag clears only by host writing one; writes other than status or general config refused meanwhile
// - under error, reads and status or general config writes still served
// - fallback forces channels analog on error; restored when flag clears
// - halt-on-fault stops autonomous and turbo conversions after an error
// - event-on-crc-error raises the threshold event on each input error
// - crc follows output packet: 8 bits register, 16 or 24 bits result
// - results leave msb first, left aligned, 16 bits averaged else 12
// - append channel id or status; status never on register or pattern data
// - status nibble is one, zero, input error flag, or of window flags
// - comparator runs only when enabled; per-channel thresholds and counts
// - analog channel flags set only after programmed count of consecutive violations
// - flags ignore the mask; only masked channels drive threshold event
// - digital input: region 0 rising sets high flag, 1 falling sets low
// - threshold event can drive one selected digital output channel
// - enabling statistics reinitializes recorders; old values stay readable
// - register write is opcode, address, data, executed at frame end
// - register read crc covers only the returned 8-bit data
`ifndef SCWCS_CONSTS_SVH
`define SCWCS_CONSTS_SVH
`define SCWCS_CRC_POLY 8'h07
`define SCWCS_CRC_INIT 8'h00
`define SCWCS_FRAME_BITS 6'h20
`define SCWCS_PAYLOAD_BITS 6'h18
`define SCWCS_LEN_PAYLOAD 5'h18
`define SCWCS_LEN_WORD 5'h10
`define SCWCS_LEN_BYTE 5'h08
`define SCWCS_OP_WRITE 8'h08
`define SCWCS_OP_READ 8'h10
`define SCWCS_ADDR_STATUS 8'h00
`define SCWCS_ADDR_GENCFG 8'h01
`define SCWCS_ERR_BIT 3'h0
`define SCWCS_APP_CHID 2'h1
`define SCWCS_APP_STAT 2'h2
`define SCWCS_FIXED_PATTERN_OUTPUT 16'hA5A0
`define SCWCS_MODE_AUTO 2'h1
`define SCWCS_MODE_TURBO 2'h2
`define SCWCS_THR_HI_RST 12'hFFF
`define SCWCS_THR_LO_RST 12'h000
`endif

/* core/scwcs_pkg.sv */
// types for the spi crc, window compare and statistics block
package scwcs_pkg;
	typedef enum logic [2:0] {
		SCWCS_IDLE = 3'b001,
		SCWCS_EXEC = 3'b010,
		SCWCS_BUILD = 3'b100
	} scwcs_state_e;
endpackage // scwcs_pkg

/* core/scwcs_top.sv */
// spi frame crc check, output packing, window comparator and statistics
`timescale 1ns/10ps
`include "scwcs_consts.svh"
module scwcs_top #(
	parameter int NCH = 8,
	parameter int DW = 12,
	parameter int HW = 4,
	parameter int CW = 4
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	// serial link
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic SDI,
	output logic SDO,
	// configuration
	input wire logic CRC_EN,
	input wire logic EVENT_ON_CRC_ERROR,
	input wire logic HALT_ON_FAULT,
	input wire logic CHANNEL_FALLBACK_ON_FAULT,
	input wire logic FIXED_PATTERN_OUTPUT,
	input wire logic [1:0] APPEND_SEL,
	input wire logic [1:0] CONV_MODE,
	// register access toward the register file
	output logic WR_STB,
	output logic [7:0] WR_ADDR,
	output logic [7:0] WR_DATA,
	output logic [7:0] RD_ADDR,
	input wire logic [7:0] RD_DATA,
	output logic INPUT_CRC_ERROR_FLAG,
	output logic CONV_HALT,
	// channel configuration
	input wire logic [NCH-1:0] PIN_CFG,
	input wire logic [NCH-1:0] GPIO_CFG,
	output logic [NCH-1:0] CH_DIGITAL,
	output logic [NCH-1:0] CH_DIR_OUT,
	// conversion results
	input wire logic CONV_VALID,
	input wire logic [2:0] CONV_CH,
	input wire logic [15:0] CONV_DATA,
	input wire logic AVG_EN,
	// window comparator
	input wire logic WINDOW_COMPARE_ENABLE,
	input wire logic [NCH-1:0] EVENT_CHANNEL_MASK,
	input wire logic [NCH-1:0] EVENT_REGION_SELECT,
	input wire logic [NCH*DW-1:0] HI_THR,
	input wire logic [NCH*DW-1:0] LO_THR,
	input wire logic [NCH*HW-1:0] HYST,
	input wire logic [NCH*CW-1:0] EVT_CNT,
	input wire logic [NCH-1:0] HI_FLAG_CLR,
	input wire logic [NCH-1:0] LO_FLAG_CLR,
	output logic [NCH-1:0] HI_FLAG,
	output logic [NCH-1:0] LO_FLAG,
	// digital inputs and event routing
	input wire logic [NCH-1:0] GPI,
	input wire logic ALERT_ROUTE_EN,
	input wire logic [2:0] ALERT_ROUTE_CH,
	output logic [NCH-1:0] ALERT_GPO,
	output logic THR_EVENT,
	// statistics
	input wire logic STATISTICS_ENABLE,
	input wire logic [2:0] STAT_SEL,
	output logic [15:0] STAT_MIN,
	output logic [15:0] STAT_MAX,
	output logic [15:0] STAT_LAST
);
	import scwcs_pkg::*;

	//------------------------------------------------------------
	// crc
	//------------------------------------------------------------
	// msb first over the first n bits of d, zero start, no final xor
	function automatic logic [7:0] crc8(input logic [23:0] d, input logic [4:0] n);
		logic [7:0] c;
		logic fb;
		c = `SCWCS_CRC_INIT;
		for (int i = 0; i < 24; i++) begin
			if (i < int'(n)) begin
				fb = c[7] ^ d[23-i];
				c = {c[6:0], 1'b0};
				if (fb) begin
					c = c ^ `SCWCS_CRC_POLY;
				end
			end
		end
		return c;
	endfunction

	//------------------------------------------------------------
	// link domain
	//------------------------------------------------------------
	logic [31:0] rx_sh_ff, tx_ff;
	logic [5:0] rx_cnt_ff, tx_idx_ff;
	logic arm_ff;

	// the receive count must outlive the frame end until the system side has read it,
	// so only the first clock of a frame restarts it; a clockless frame repeats the last
	always_ff @(posedge SCLK or posedge CS_N) begin
		if (CS_N) begin
			arm_ff <= 1'b1;
		end else begin
			arm_ff <= 1'b0;
		end
	end

	always_ff @(posedge SCLK) begin
		rx_sh_ff <= {rx_sh_ff[30:0], SDI};
		if (arm_ff) begin
			rx_cnt_ff <= 6'h01;
		end else if (rx_cnt_ff != 6'h3F) begin
			rx_cnt_ff <= rx_cnt_ff + 6'h01;
		end
	end

	always_ff @(negedge SCLK or posedge CS_N) begin
		if (CS_N) begin
			tx_idx_ff <= 6'h00;
		end else if (tx_idx_ff != 6'h3F) begin
			tx_idx_ff <= tx_idx_ff + 6'h01;
		end
	end

	// tx_ff only changes just after a frame ends, so it is static here
	assign SDO = (tx_idx_ff < 6'h20) ? tx_ff[5'h1F - tx_idx_ff[4:0]] : 1'b0;

	//------------------------------------------------------------
	// frame end detection
	//------------------------------------------------------------
	logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_s3_ff <= 1'b1;
		end else begin
			cs_s1_ff <= CS_N;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
		end
	end
	wire cs_rise = cs_s2_ff & ~cs_s3_ff;

	//------------------------------------------------------------
	// command decode
	//------------------------------------------------------------
	scwcs_state_e st_ff, nxt_st;
	logic err_ff, rd_pend_ff, crc_evt_ff;
	// rx_sh_ff and rx_cnt_ff are quasi-static once chip select is high
	wire [23:0] payload = CRC_EN ? rx_sh_ff[31:8] : rx_sh_ff[23:0];
	wire [7:0] op = payload[23:16];
	wire [7:0] addr = payload[15:8];
	wire [7:0] wdata = payload[7:0];
	wire crc_ok = crc8(rx_sh_ff[31:8], `SCWCS_LEN_PAYLOAD) == rx_sh_ff[7:0];
	wire len_bad = rx_cnt_ff != `SCWCS_FRAME_BITS;
	wire frame_bad = CRC_EN & (len_bad | ~crc_ok);
	wire frame_ok = CRC_EN ? ~frame_bad : (rx_cnt_ff >= `SCWCS_PAYLOAD_BITS);
	wire wr_cfg = (addr == `SCWCS_ADDR_STATUS) | (addr == `SCWCS_ADDR_GENCFG);
	wire wr_go = frame_ok & (op == `SCWCS_OP_WRITE) & (~err_ff | wr_cfg);
	wire rd_go = frame_ok & (op == `SCWCS_OP_READ);
	wire err_clr = wr_go & (addr == `SCWCS_ADDR_STATUS) & wdata[`SCWCS_ERR_BIT];

	always_comb begin
		case (st_ff)
			SCWCS_IDLE: nxt_st = cs_rise ? SCWCS_EXEC : SCWCS_IDLE;
			SCWCS_EXEC: nxt_st = SCWCS_BUILD;
			SCWCS_BUILD: nxt_st = SCWCS_IDLE;
			default: nxt_st = SCWCS_IDLE;
		endcase
	end

	wire exec = st_ff == SCWCS_EXEC;
	wire err_set = exec & frame_bad;
	// a new error in the same cycle as a clear wins
	wire nxt_err = err_set | (err_ff & ~(exec & err_clr));

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			st_ff <= SCWCS_IDLE;
			err_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			crc_evt_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			err_ff <= nxt_err;
			rd_pend_ff <= exec ? rd_go : rd_pend_ff;
			crc_evt_ff <= err_set & EVENT_ON_CRC_ERROR;
		end
	end

	logic wr_stb_ff;
	logic [7:0] wr_addr_ff, wr_data_ff, rd_addr_ff;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			wr_stb_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			wr_data_ff <= 8'h00;
			rd_addr_ff <= 8'h00;
		end else begin
			wr_stb_ff <= exec & wr_go;
			wr_addr_ff <= (exec & wr_go) ? addr : wr_addr_ff;
			wr_data_ff <= (exec & wr_go) ? wdata : wr_data_ff;
			rd_addr_ff <= (exec & rd_go) ? addr : rd_addr_ff;
		end
	end

	//------------------------------------------------------------
	// output packet
	//------------------------------------------------------------
	logic [15:0] lat_data_ff;
	logic [2:0] lat_ch_ff;
	logic lat_avg_ff;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			lat_data_ff <= 16'h0000;
			lat_ch_ff <= 3'h0;
			lat_avg_ff <= 1'b0;
		end else if (CONV_VALID) begin
			lat_data_ff <= CONV_DATA;
			lat_ch_ff <= CONV_CH;
			lat_avg_ff <= AVG_EN;
		end
	end

	logic [NCH-1:0] hi_ff, lo_ff, fresh_ff;
	wire any_flag = |(hi_ff | lo_ff);
	wire [15:0] res_al = lat_avg_ff ? lat_data_ff : {lat_data_ff[11:0], 4'h0};
	wire [15:0] dat16 = FIXED_PATTERN_OUTPUT ? `SCWCS_FIXED_PATTERN_OUTPUT : res_al;
	wire app_stat = (APPEND_SEL == `SCWCS_APP_STAT) & ~FIXED_PATTERN_OUTPUT;
	wire app_chid = APPEND_SEL == `SCWCS_APP_CHID;
	wire [3:0] stat4 = {1'b1, 1'b0, err_ff, any_flag};
	wire [3:0] app4 = app_stat ? stat4 : (app_chid ? {1'b0, lat_ch_ff} : 4'h0);
	wire long_pkt = lat_avg_ff & (app_stat | app_chid);
	wire [15:0] short16 = lat_avg_ff ? dat16 : {dat16[15:4], app4};
	wire [23:0] pkt24 = long_pkt ? {dat16, app4, 4'h0} : {short16, 8'h00};
	wire [7:0] crc_c24 = crc8(pkt24, `SCWCS_LEN_PAYLOAD);
	wire [7:0] crc_c16 = crc8(pkt24, `SCWCS_LEN_WORD);
	wire [31:0] conv_tx = ~CRC_EN ? {pkt24, 8'h00} :
		(long_pkt ? {pkt24, crc_c24} : {short16, crc_c16, 8'h00});
	wire [7:0] crc_rd = crc8({RD_DATA, 16'h0000}, `SCWCS_LEN_BYTE);
	// register data never carries the status nibble
	wire [31:0] reg_tx = CRC_EN ? {RD_DATA, crc_rd, 16'h0000} : {RD_DATA, 24'h000000};

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			tx_ff <= 32'h0000_0000;
		end else if (st_ff == SCWCS_BUILD) begin
			tx_ff <= rd_pend_ff ? reg_tx : conv_tx;
		end
	end

	//------------------------------------------------------------
	// channel configuration and halt
	//------------------------------------------------------------
	wire force_an = CHANNEL_FALLBACK_ON_FAULT & nxt_err;
	wire auto_mode = (CONV_MODE == `SCWCS_MODE_AUTO) | (CONV_MODE == `SCWCS_MODE_TURBO);
	logic [NCH-1:0] ch_dig_ff, ch_out_ff;
	logic halt_ff;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ch_dig_ff <= '0;
			ch_out_ff <= '0;
			halt_ff <= 1'b0;
		end else begin
			ch_dig_ff <= force_an ? '0 : PIN_CFG;
			ch_out_ff <= force_an ? '0 : (PIN_CFG & GPIO_CFG);
			halt_ff <= HALT_ON_FAULT & nxt_err & auto_mode;
		end
	end

	//------------------------------------------------------------
	// window comparator and statistics, per channel
	//------------------------------------------------------------
	logic [NCH-1:0] gpi_s1_ff, gpi_s2_ff, gpi_s3_ff;
	logic statistics_enable_d_ff;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			gpi_s1_ff <= '0;
			gpi_s2_ff <= '0;
			gpi_s3_ff <= '0;
			statistics_enable_d_ff <= 1'b0;
		end else begin
			gpi_s1_ff <= GPI;
			gpi_s2_ff <= gpi_s1_ff;
			gpi_s3_ff <= gpi_s2_ff;
			statistics_enable_d_ff <= STATISTICS_ENABLE;
		end
	end
	wire [NCH-1:0] gpi_rise = gpi_s2_ff & ~gpi_s3_ff;
	wire [NCH-1:0] gpi_fall = ~gpi_s2_ff & gpi_s3_ff;
	wire stats_init = STATISTICS_ENABLE & ~statistics_enable_d_ff;
	wire [DW-1:0] samp = AVG_EN ? CONV_DATA[15:4] : CONV_DATA[11:0];
	wire [15:0] samp16 = AVG_EN ? CONV_DATA : {CONV_DATA[11:0], 4'h0};

	logic [15:0] st_min_ff [NCH], st_max_ff [NCH], st_last_ff [NCH];

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic [CW-1:0] hc_ff, lc_ff;
			wire [DW-1:0] hi_t = HI_THR[g*DW +: DW];
			wire [DW-1:0] lo_t = LO_THR[g*DW +: DW];
			wire [DW:0] hy = {{(DW+1-HW){1'b0}}, HYST[g*HW +: HW]};
			wire [CW-1:0] ec = EVT_CNT[g*CW +: CW];
			wire mine = CONV_VALID & (CONV_CH == 3'(g)) & ~PIN_CFG[g];
			wire hit = mine & WINDOW_COMPARE_ENABLE;
			wire over = samp > hi_t;
			wire under = samp < lo_t;
			// hysteresis: a count only restarts once the sample is well back in
			wire hi_back = ({1'b0, samp} + hy) <= {1'b0, hi_t};
			wire lo_back = {1'b0, samp} >= ({1'b0, lo_t} + hy);
			wire [CW-1:0] hc_inc = (&hc_ff) ? hc_ff : hc_ff + CW'(1);
			wire [CW-1:0] lc_inc = (&lc_ff) ? lc_ff : lc_ff + CW'(1);
			wire [CW-1:0] nxt_hc = over ? hc_inc : (hi_back ? '0 : hc_ff);
			wire [CW-1:0] nxt_lc = under ? lc_inc : (lo_back ? '0 : lc_ff);
			wire dig_in = WINDOW_COMPARE_ENABLE & PIN_CFG[g] & ~GPIO_CFG[g];
			wire hi_set = (hit & over & (nxt_hc > ec)) |
				(dig_in & ~EVENT_REGION_SELECT[g] & gpi_rise[g]);
			wire lo_set = (hit & under & (nxt_lc > ec)) |
				(dig_in & EVENT_REGION_SELECT[g] & gpi_fall[g]);
			wire st_hit = mine & STATISTICS_ENABLE;

			always_ff @(posedge REF_CLK) begin
				if (RESET) begin
					hc_ff <= '0;
					lc_ff <= '0;
					hi_ff[g] <= 1'b0;
					lo_ff[g] <= 1'b0;
				end else begin
					hc_ff <= hit ? nxt_hc : hc_ff;
					lc_ff <= hit ? nxt_lc : lc_ff;
					hi_ff[g] <= hi_set | (hi_ff[g] & ~HI_FLAG_CLR[g]);
					lo_ff[g] <= lo_set | (lo_ff[g] & ~LO_FLAG_CLR[g]);
				end
			end

			// reinit only marks the recorder; the old values stay until a result
			always_ff @(posedge REF_CLK) begin
				if (RESET) begin
					fresh_ff[g] <= 1'b1;
					st_min_ff[g] <= 16'hFFFF;
					st_max_ff[g] <= 16'h0000;
					st_last_ff[g] <= 16'h0000;
				end else if (st_hit) begin
					fresh_ff[g] <= 1'b0;
					st_last_ff[g] <= samp16;
					st_min_ff[g] <= (fresh_ff[g] | stats_init | (samp16 < st_min_ff[g])) ?
						samp16 : st_min_ff[g];
					st_max_ff[g] <= (fresh_ff[g] | stats_init | (samp16 > st_max_ff[g])) ?
						samp16 : st_max_ff[g];
				end else if (stats_init) begin
					fresh_ff[g] <= 1'b1;
				end
			end
		end
	endgenerate

	//------------------------------------------------------------
	// threshold event and routing
	//------------------------------------------------------------
	wire nxt_evt = (|((hi_ff | lo_ff) & EVENT_CHANNEL_MASK)) | crc_evt_ff;
	logic evt_ff;
	logic [NCH-1:0] gpo_ff;
	logic [15:0] smin_ff, smax_ff, slast_ff;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			evt_ff <= 1'b0;
			gpo_ff <= '0;
			smin_ff <= 16'h0000;
			smax_ff <= 16'h0000;
			slast_ff <= 16'h0000;
		end else begin
			evt_ff <= nxt_evt;
			for (int i = 0; i < NCH; i++) begin
				gpo_ff[i] <= ALERT_ROUTE_EN & (ALERT_ROUTE_CH == 3'(i)) & ch_out_ff[i] &
					nxt_evt;
			end
			smin_ff <= st_min_ff[STAT_SEL];
			smax_ff <= st_max_ff[STAT_SEL];
			slast_ff <= st_last_ff[STAT_SEL];
		end
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	assign {WR_STB, WR_ADDR, WR_DATA, RD_ADDR} = {wr_stb_ff, wr_addr_ff, wr_data_ff, rd_addr_ff};
	assign {INPUT_CRC_ERROR_FLAG, CONV_HALT, THR_EVENT} = {err_ff, halt_ff, evt_ff};
	assign {CH_DIGITAL, CH_DIR_OUT} = {ch_dig_ff, ch_out_ff};
	assign {HI_FLAG, LO_FLAG, ALERT_GPO} = {hi_ff, lo_ff, gpo_ff};
	assign {STAT_MIN, STAT_MAX, STAT_LAST} = {smin_ff, smax_ff, slast_ff};
endmodule // scwcs_top

/* testbench/scwcs_top_chk.sv */
// concurrent checks on the top ports of the crc, window and statistics block
`timescale 1ns/10ps
module scwcs_top_chk #(
	parameter int NCH = 8
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	// frame execution
	input wire logic WR_STB,
	input wire logic [7:0] WR_ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic INPUT_CRC_ERROR_FLAG,
	input wire logic EVENT_ON_CRC_ERROR,
	input wire logic HALT_ON_FAULT,
	input wire logic CHANNEL_FALLBACK_ON_FAULT,
	input wire logic [1:0] CONV_MODE,
	input wire logic CONV_HALT,
	// channels and events
	input wire logic [NCH-1:0] PIN_CFG,
	input wire logic [NCH-1:0] GPIO_CFG,
	input wire logic [NCH-1:0] CH_DIGITAL,
	input wire logic [NCH-1:0] HI_FLAG,
	input wire logic [NCH-1:0] LO_FLAG,
	input wire logic [NCH-1:0] HI_FLAG_CLR,
	input wire logic [NCH-1:0] EVENT_CHANNEL_MASK,
	input wire logic THR_EVENT
);
	// ------------------------------
	// properties
	// ------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);

	sequence s_fault_held;
		(CHANNEL_FALLBACK_ON_FAULT && INPUT_CRC_ERROR_FLAG) [*2];
	endsequence
	// channel outputs are registered, so the setup has to sit still a while
	sequence s_setup_quiet;
		(!INPUT_CRC_ERROR_FLAG && $stable(PIN_CFG) && $stable(GPIO_CFG)) [*3];
	endsequence
	sequence s_halt_armed;
		(HALT_ON_FAULT && INPUT_CRC_ERROR_FLAG && CONV_MODE inside {2'h1, 2'h2}) [*2];
	endsequence

	chk_wr_single: assert property (WR_STB |=> !WR_STB)
		else $error("write strobe wider than one cycle");
	chk_err_blocks_wr: assert property (
		WR_STB && $past(INPUT_CRC_ERROR_FLAG) |-> WR_ADDR <= 8'h01)
		else $error("write passed while input error flag set");
	chk_flag_w1c: assert property ($fell(INPUT_CRC_ERROR_FLAG) |->
		(WR_STB || $past(WR_STB)) && WR_ADDR == 8'h00 && WR_DATA[0])
		else $error("input error flag cleared without a clearing write");
	chk_fallback_on: assert property (s_fault_held |-> CH_DIGITAL == '0)
		else $error("channels not forced analog on input error");
	chk_fallback_off: assert property (s_setup_quiet |-> CH_DIGITAL == PIN_CFG)
		else $error("channel setup not restored");
	chk_halt_conv: assert property (s_halt_armed |-> CONV_HALT)
		else $error("conversions not halted on input error");
	chk_evt_mask: assert property (
		|((HI_FLAG | LO_FLAG) & EVENT_CHANNEL_MASK) |=> THR_EVENT)
		else $error("masked flag did not raise threshold event");
	chk_evt_quiet: assert property (
		!(|((HI_FLAG | LO_FLAG) & EVENT_CHANNEL_MASK)) && !EVENT_ON_CRC_ERROR |=> !THR_EVENT)
		else $error("threshold event without a cause");
	chk_crc_event: assert property (
		$rose(INPUT_CRC_ERROR_FLAG) && EVENT_ON_CRC_ERROR |-> ##[1:4] THR_EVENT)
		else $error("no threshold event after input error");
	chk_flag_sticky: assert property (
		1'b1 |-> ($past(HI_FLAG) & ~$past(HI_FLAG_CLR) & ~HI_FLAG) == '0)
		else $error("high flag dropped without a clear");
endmodule // scwcs_top_chk

bind scwcs_top scwcs_top_chk #(.NCH(NCH)) u_chk (
	.REF_CLK, .RESET, .WR_STB, .WR_ADDR, .WR_DATA, .INPUT_CRC_ERROR_FLAG,
	.EVENT_ON_CRC_ERROR, .HALT_ON_FAULT, .CHANNEL_FALLBACK_ON_FAULT, .CONV_MODE,
	.CONV_HALT, .PIN_CFG, .GPIO_CFG, .CH_DIGITAL, .HI_FLAG, .LO_FLAG, .HI_FLAG_CLR,
	.EVENT_CHANNEL_MASK, .THR_EVENT
);

/* testbench/scwcs_host.sv */
// serial host model sending mode 00 frames with a trailing crc
`timescale 1ns/10ps
module scwcs_host (
	// serial link
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// poly 07, zero start, msb first, no final inversion
	function automatic logic [7:0] crc8(input logic [23:0] d, input int nb);
		logic [7:0] c;
		c = 8'h00;
		for (int i = nb - 1; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// link clock runs only inside a frame, 30 ns period
	task automatic frame(input int nb, input logic [31:0] w, output logic [31:0] rx);
		rx = '0;
		#7 cs_n = 1'b0;
		for (int i = nb - 1; i >= 0; i--) begin
			sdi = w[i];
			#15 sclk = 1'b1;
			rx = {rx[30:0], sdo};
			#15 sclk = 1'b0;
		end
		#9 cs_n = 1'b1;
		// released line must not keep looking valid
		sdi = ~sdi;
		#150;
	endtask
	task automatic cmd(input logic [23:0] p, output logic [31:0] rx);
		frame(32, {p, crc8(p, 24)}, rx);
	endtask
endmodule // scwcs_host

/* testbench/spi_crc_window_compare_stats_bench.sv */
// self-checking bench for the crc, window compare and statistics block
`timescale 1ns/10ps
module spi_crc_window_compare_stats_bench;
	logic REF_CLK, RESET, SCLK, CS_N, SDI, SDO, CRC_EN, EVENT_ON_CRC_ERROR, HALT_ON_FAULT;
	logic CHANNEL_FALLBACK_ON_FAULT, FIXED_PATTERN_OUTPUT, WR_STB, INPUT_CRC_ERROR_FLAG;
	logic CONV_HALT, CONV_VALID, AVG_EN, WINDOW_COMPARE_ENABLE, ALERT_ROUTE_EN, THR_EVENT;
	logic STATISTICS_ENABLE;
	logic [1:0] APPEND_SEL, CONV_MODE;
	logic [2:0] CONV_CH, ALERT_ROUTE_CH, STAT_SEL;
	logic [7:0] WR_ADDR, WR_DATA, RD_ADDR, RD_DATA, PIN_CFG, GPIO_CFG, CH_DIGITAL, CH_DIR_OUT;
	logic [7:0] EVENT_CHANNEL_MASK, EVENT_REGION_SELECT, HI_FLAG_CLR, LO_FLAG_CLR, HI_FLAG;
	logic [7:0] LO_FLAG, GPI, ALERT_GPO;
	logic [15:0] CONV_DATA, STAT_MIN, STAT_MAX, STAT_LAST;
	logic [95:0] HI_THR, LO_THR;
	logic [31:0] HYST, EVT_CNT;
	int num_errors = 0, checks_done = 0, cycles = 0, n_stb = 0, n_evt = 0;

	scwcs_top dut (.*);
	scwcs_host host (.sclk(SCLK), .cs_n(CS_N), .sdi(SDI), .sdo(SDO));
	// register file stand-in: a fixed scramble of the address
	assign RD_DATA = RD_ADDR ^ 8'h5A;
	always #5 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) begin
		cycles++;
		n_stb += WR_STB;
		n_evt += THR_EVENT;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	function automatic logic [31:0] pkt(input logic [7:0] op, a, d);
		return {op, a, d, host.crc8({op, a, d}, 24)};
	endfunction
	task automatic wr(input logic [31:0] w, input int nb, input logic ok);
		logic [31:0] rx;
		int n0;
		n0 = n_stb;
		host.frame(nb, w, rx);
		tick(1);
		cmp(n_stb - n0, ok, "strobe count");
		if (ok)
			cmp({WR_ADDR, WR_DATA}, w[23:8], "write fields");
	endtask
	task automatic conv(input logic [2:0] ch, input logic [15:0] d);
		tick(1);
		CONV_CH = ch;
		CONV_DATA = d;
		CONV_VALID = 1'b1;
		tick(1);
		CONV_VALID = 1'b0;
		tick(2);
	endtask
	// first frame loads the new result, the second one carries it out
	task automatic rd_out(input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] rx;
		host.cmd(24'h0, rx);
		host.cmd(24'h0, rx);
		tick(1);
		cmp(rx & mask, exp, "output word");
	endtask

	task automatic t_crc_errors();
		logic [31:0] rx;
		int e0;
		wr(pkt(8'h08, 8'h05, 8'h3C), 32, 1'b1);
		e0 = n_evt;
		wr(pkt(8'h08, 8'h06, 8'h11), 31, 1'b0);
		cmp(INPUT_CRC_ERROR_FLAG, 1'b1, "flag after short frame");
		cmp(n_evt - e0, 1, "event on error");
		cmp({CH_DIGITAL, CH_DIR_OUT}, 16'h0000, "fallback");
		cmp(CONV_HALT, 1'b1, "halt");
		CONV_MODE = 2'h2;
		tick(2);
		cmp(CONV_HALT, 1'b1, "halt in turbo");
		CONV_MODE = 2'h0;
		tick(2);
		cmp(CONV_HALT, 1'b0, "manual mode not halted");
		CONV_MODE = 2'h1;
		wr(pkt(8'h08, 8'h07, 8'h22), 32, 1'b0);
		wr(pkt(8'h08, 8'h01, 8'h40), 32, 1'b1);
		host.cmd({8'h10, 8'h33, 8'h00}, rx);
		host.cmd(24'h0, rx);
		cmp(RD_ADDR, 8'h33, "read address");
		cmp(rx, {8'h69, host.crc8(8'h69, 8), 16'h0}, "read reply");
		wr(pkt(8'h08, 8'h00, 8'h01), 32, 1'b1);
		cmp(INPUT_CRC_ERROR_FLAG, 1'b0, "flag cleared");
		cmp({CH_DIGITAL, CH_DIR_OUT}, 16'h6808, "channels restored");
		e0 = n_evt;
		wr(pkt(8'h08, 8'h09, 8'h55) ^ 32'h1, 32, 1'b0);
		cmp({INPUT_CRC_ERROR_FLAG, 8'(n_evt - e0)}, 9'h101, "flag on mismatch");
		wr(pkt(8'h08, 8'h00, 8'h01), 32, 1'b1);
		EVENT_ON_CRC_ERROR = 1'b0;
	endtask
	task automatic t_window();
		HI_THR[35:24] = 12'h800;
		LO_THR[35:24] = 12'h100;
		EVT_CNT[11:8] = 4'h2;
		repeat (4) conv(3'h2, 16'h0900);
		cmp(HI_FLAG, 8'h00, "compare disabled");
		WINDOW_COMPARE_ENABLE = 1'b1;
		repeat (2) conv(3'h2, 16'h0900);
		conv(3'h2, 16'h0700);
		repeat (2) conv(3'h2, 16'h0900);
		cmp(HI_FLAG, 8'h00, "transient rejected");
		conv(3'h2, 16'h0900);
		cmp(HI_FLAG, 8'h04, "high flag on count");
		repeat (3) conv(3'h2, 16'h0050);
		cmp({LO_FLAG, THR_EVENT}, 9'h008, "low flag, masked");
		EVENT_CHANNEL_MASK = 8'h04;
		{ALERT_ROUTE_EN, ALERT_ROUTE_CH} = 4'hB;
		tick(3);
		cmp({THR_EVENT, ALERT_GPO}, 9'h108, "event routed");
		LO_FLAG_CLR = 8'h04;
		tick(1);
		LO_FLAG_CLR = 8'h00;
		tick(2);
		cmp(LO_FLAG, 8'h00, "low flag cleared");
	endtask
	task automatic t_gpi();
		EVENT_REGION_SELECT = 8'h40;
		GPI = 8'h40;
		tick(6);
		cmp({HI_FLAG[6:5], LO_FLAG[6:5]}, 4'h0, "wrong edges ignored");
		GPI = 8'h20;
		tick(6);
		cmp({HI_FLAG[6:5], LO_FLAG[6:5]}, 4'h6, "edge flags");
	endtask
	task automatic t_out_format();
		conv(3'h2, 16'h0ABC);
		rd_out({16'hABC9, host.crc8(16'hABC9, 16), 8'h0}, 32'hFFFF_FF00);
		APPEND_SEL = 2'h1;
		conv(3'h2, 16'h0ABC);
		rd_out({16'hABC2, host.crc8(16'hABC2, 16), 8'h0}, 32'hFFFF_FF00);
		{AVG_EN, APPEND_SEL} = 3'h4;
		conv(3'h2, 16'hABCD);
		rd_out({16'hABCD, host.crc8(16'hABCD, 16), 8'h0}, 32'hFFFF_FF00);
		APPEND_SEL = 2'h2;
		conv(3'h2, 16'hABCD);
		rd_out({24'hABCD90, host.crc8(24'hABCD90, 24)}, 32'hFFFF_FFFF);
		FIXED_PATTERN_OUTPUT = 1'b1;
		conv(3'h2, 16'hABCD);
		rd_out({16'hA5A0, 16'h0}, 32'hFFFF_0000);
		FIXED_PATTERN_OUTPUT = 1'b0;
	endtask
	task automatic t_stats();
		{AVG_EN, STAT_SEL, STATISTICS_ENABLE} = 5'h13;
		tick(2);
		conv(3'h1, 16'h3000);
		conv(3'h1, 16'h1000);
		conv(3'h1, 16'h2000);
		cmp({STAT_MIN, STAT_MAX, STAT_LAST}, 48'h1000_3000_2000, "recorded");
		STATISTICS_ENABLE = 1'b0;
		tick(2);
		STATISTICS_ENABLE = 1'b1;
		tick(2);
		cmp({STAT_MIN, STAT_MAX, STAT_LAST}, 48'h1000_3000_2000, "old values kept");
		conv(3'h1, 16'h0400);
		cmp({STAT_MIN, STAT_MAX, STAT_LAST}, 48'h0400_0400_0400, "reinitialised");
	endtask

	initial begin
		{REF_CLK, RESET, CONV_VALID, AVG_EN, FIXED_PATTERN_OUTPUT, STATISTICS_ENABLE} = 6'h10;
		{CRC_EN, EVENT_ON_CRC_ERROR, HALT_ON_FAULT, CHANNEL_FALLBACK_ON_FAULT} = 4'hF;
		{WINDOW_COMPARE_ENABLE, ALERT_ROUTE_EN, APPEND_SEL, CONV_MODE} = 6'h09;
		{CONV_CH, ALERT_ROUTE_CH, STAT_SEL, CONV_DATA} = '0;
		{PIN_CFG, GPIO_CFG} = 16'h6808;
		{EVENT_CHANNEL_MASK, EVENT_REGION_SELECT, HI_FLAG_CLR, LO_FLAG_CLR, GPI} = '0;
		HI_THR = {8{12'hFFF}};
		{LO_THR, HYST, EVT_CNT} = '0;
		tick(12);
		RESET = 1'b0;
		tick(1);
		t_crc_errors();
		t_window();
		t_gpi();
		t_out_format();
		t_stats();
		wrap_up();
	end
endmodule // spi_crc_window_compare_stats_bench
